// ---- dv/fcsm_flash_model.sv ----
// behavioural flash device model on the far side of the host controller pins
module fcsm_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h3C5A, // arbitrary value
    parameter logic [5:0]  PROT_SEC   = 6'h05,
    parameter int          BUSY_READS = 5
) (
    // flash pins
    input  wire logic        ceN,
    input  wire logic        weN,
    input  wire logic        oeN,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] hostDq,
    input  wire logic        hostDqOe,
    // resolved data wire and ready/busy
    output logic      [15:0] dqWire,
    output logic             readyBusy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] mem [logic [21:0]];
    logic [21:0] aLat;
    logic [15:0] rdVal = 16'h0000;
    logic [15:0] lastQ = 16'h0000;
    logic        tog = 1'b0;
    logic        errQ = 1'b0;
    logic        idMode = 1'b0;
    logic        armProg = 1'b0;
    logic        armErase = 1'b0;
    int          step = 0;
    int          busyCnt = 0;
    wire         wrN = ceN | weN | ~oeN;

    // unwritten words read as erased
    function automatic logic [15:0] rd(input logic [21:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    always @(negedge wrN) aLat = addr;

    always @(posedge wrN) begin
        if (busyCnt > 0) begin
            if (errQ && hostDq[7:0] == 8'hF0) begin
                errQ = 1'b0;
                busyCnt = 0;
            end
        end else if (hostDq[7:0] == 8'hF0) begin
            step = 0;
            idMode = 1'b0;
            armProg = 1'b0;
            armErase = 1'b0;
        end else if (armProg) begin
            errQ = |(hostDq & ~rd(aLat));
            mem[aLat] = hostDq & rd(aLat);
            armProg = 1'b0;
            busyCnt = BUSY_READS;
        end else if (step == 0 && aLat[10:0] == 11'h555 && hostDq[7:0] == 8'hAA) begin
            step = 1;
        end else if (step == 1 && aLat[10:0] == 11'h2AA && hostDq[7:0] == 8'h55) begin
            step = 2;
        end else if (step == 2) begin
            step = 0;
            case (hostDq[7:0])
                8'h90: idMode = 1'b1;
                8'hA0: armProg = 1'b1;
                8'h10, 8'h30: if (armErase) begin
                    foreach (mem[k]) if (hostDq[7:0] == 8'h10 || k[21:16] == aLat[21:16])
                        mem[k] = 16'hFFFF;
                    busyCnt = BUSY_READS;
                end
                default: ;
            endcase
            armErase = (hostDq[7:0] == 8'h80);
        end else begin
            // suspend or resume outside an erase is ignored
            step = 0;
            armErase = 1'b0;
        end
    end

    always @(negedge oeN) begin
        if (busyCnt > 0) rdVal = {9'h000, tog, errQ, 5'h00};
        else if (!idMode) rdVal = rd(addr);
        else if (addr[7:0] == 8'h00) rdVal = MAKER_CODE;
        else if (addr[7:0] == 8'h01) rdVal = PART_CODE;
        else rdVal = {15'h0000, addr[7:0] == 8'h02 && addr[21:16] == PROT_SEC};
    end

    // each read ends: toggle status, count the algorithm down unless it has failed
    always @(posedge oeN) begin
        lastQ = rdVal;
        tog = ~tog;
        if (busyCnt > 0 && !errQ) busyCnt--;
    end

    // released bus shows the inverse of the last word, so stale data never passes
    assign dqWire = hostDqOe ? hostDq : (!ceN && !oeN) ? rdVal : ~lastQ;
    assign readyBusy = (busyCnt == 0);
endmodule // fcsm_flash_model

// ---- dv/testbench.sv ----
// self-checking bench for the flash host controller against the flash model
`include "fcsm_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, ceN, weN, oeN, dqOe, rdyBusy, e;
    logic [21:0] fAddr;
    logic [15:0] dqOut, dqWire, maker, part;
    int          err_total = 0, check_count = 0;

    fcsm_host u_fcsm_host (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashCeN(ceN), .flashWeN(weN), .flashOeN(oeN), .flashAddr(fAddr),
        .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqWire), .readyBusyIn(rdyBusy));
    fcsm_flash_model u_fcsm_flash_model (.ceN(ceN), .weN(weN), .oeN(oeN), .addr(fAddr),
        .hostDq(dqOut), .hostDqOe(dqOe), .dqWire(dqWire), .readyBusy(rdyBusy));
    assign maker = u_fcsm_flash_model.MAKER_CODE;
    assign part = u_fcsm_flash_model.PART_CODE;

    // free-running 250 MHz clock
    initial forever #2 clk = ~clk;

    // verdict and end of run
    task automatic finish_test();
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // compare one value
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask

    // one apb transfer, result left in q and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_total++;
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // launch an operation and poll until not busy; last status stays in q
    task automatic run(input fcsm_pkg::fcsm_op_e op, input logic [21:0] a, input logic [15:0] d);
        int n;
        apb(1'b1, `FCSM_REG_ADDR, {10'h000, a});
        apb(1'b1, `FCSM_REG_WDATA, {16'h0000, d});
        apb(1'b1, `FCSM_REG_CTRL, {25'h0, op, 4'h1});
        n = 0;
        do begin
            apb(1'b0, `FCSM_REG_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            err_total++;
            finish_test();
        end
    endtask

    // read one flash word through the controller and compare
    task automatic rdw(input logic [21:0] a, input logic [31:0] exp);
        run(fcsm_pkg::OP_READ, a, 16'h0000);
        apb(1'b0, `FCSM_REG_RDATA, 32'h0);
        chk(q, exp);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        rdw(22'h012345, 32'hFFFF);
        run(fcsm_pkg::OP_PROGRAM, 22'h012345, 16'h1234);
        chk(q, 32'h4);
        rdw(22'h012345, 32'h1234);
        run(fcsm_pkg::OP_PROGRAM, 22'h012345, 16'hFF00);
        chk(q & 32'h2, 32'h2);
        rdw(22'h012345, 32'h1200);
        run(fcsm_pkg::OP_IDENT, 22'h000000, 16'h0000);
        rdw(22'h3F0000, {16'h0, maker});
        rdw(22'h3F0001, {16'h0, part});
        rdw(22'h050002, 32'h1);
        rdw(22'h250002, 32'h0);
        rdw(22'h000000, {16'h0, maker});
        run(fcsm_pkg::OP_RESET, 22'h3FFFFF, 16'h0000);
        rdw(22'h012345, 32'h1200);
        run(fcsm_pkg::OP_PROGRAM, 22'h020010, 16'h5A5A);
        run(fcsm_pkg::OP_SECTOR_ERASE, 22'h010000, 16'h0000);
        rdw(22'h012345, 32'hFFFF);
        rdw(22'h020010, 32'h5A5A);
        run(fcsm_pkg::OP_CHIP_ERASE, 22'h000000, 16'h0000);
        chk(q, 32'h4);
        rdw(22'h020010, 32'hFFFF);
        run(fcsm_pkg::OP_SUSPEND, 22'h000000, 16'h0000);
        run(fcsm_pkg::OP_RESUME, 22'h000000, 16'h0000);
        rdw(22'h020010, 32'hFFFF);
        finish_test();
    end
endmodule // testbench

// ---- rtl/fcsm_bus_cycle.sv ----
// one asynchronous write or read cycle on the flash pins
`include "fcsm_params.svh"
module fcsm_bus_cycle (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // request
    input  wire logic                 start,
    input  wire fcsm_pkg::fcsm_cycle_s cyc,
    output logic                      done,
    output logic [15:0]               rdata,
    // flash pins
    output fcsm_pkg::fcsm_pins_s      pins,
    input  wire logic [15:0]          dqIn
);
    typedef enum {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fcsm_phase_e;
    localparam int SETUP_C  = `FCSM_CYC(`FCSM_T_SETUP_NS);
    localparam int STROBE_C = `FCSM_CYC(`FCSM_T_STROBE_NS);
    localparam int READ_C   = `FCSM_CYC(`FCSM_T_READ_NS);
    localparam int HOLD_C   = `FCSM_CYC(`FCSM_T_HOLD_NS);

    fcsm_phase_e          phase_ff, nxt_phase;
    logic [7:0]           cnt_ff, nxt_cnt;
    fcsm_pkg::fcsm_pins_s pins_ff, nxt_pins;
    logic                 done_ff, nxt_done;
    logic [15:0]          rdata_ff, nxt_rdata;

    // pin sequencer: the write or read strobe alone falls after address setup, and rises together with chip enable,
    // so the device latches the address on the fall and data on the rise
    always_comb begin
        nxt_phase = phase_ff;
        nxt_cnt   = cnt_ff;
        nxt_pins  = pins_ff;
        nxt_done  = 1'b0;
        nxt_rdata = rdata_ff;
        case (phase_ff)
            PH_IDLE: begin
                if (start) begin
                    nxt_pins.addr = cyc.addr;
                    nxt_pins.dq   = cyc.data;
                    nxt_pins.dqOe = cyc.write;
                    nxt_pins.ceN  = 1'b0;
                    nxt_cnt       = 8'(SETUP_C);
                    nxt_phase     = PH_SETUP;
                end
            end
            PH_SETUP: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff <= 8'h01) begin
                    // RULE_02 address fall edge
                    nxt_pins.weN = ~pins_ff.dqOe;
                    nxt_pins.oeN = pins_ff.dqOe;
                    nxt_cnt      = pins_ff.dqOe ? 8'(STROBE_C) : 8'(READ_C);
                    nxt_phase    = PH_STROBE;
                end
            end
            PH_STROBE: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff <= 8'h01) begin
                    // RULE_02 data rise edge
                    nxt_rdata    = dqIn;
                    nxt_pins.weN = 1'b1;
                    nxt_pins.oeN = 1'b1;
                    nxt_pins.ceN = 1'b1;
                    nxt_cnt      = 8'(HOLD_C);
                    nxt_phase    = PH_HOLD;
                end
            end
            PH_HOLD: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff <= 8'h01) begin
                    nxt_pins.dqOe = 1'b0;
                    nxt_done      = 1'b1;
                    nxt_phase     = PH_IDLE;
                end
            end
            default: nxt_phase = PH_IDLE;
        endcase
    end

    // registers only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_ff <= PH_IDLE;
            cnt_ff   <= 8'h00;
            pins_ff  <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: 22'h000000,
                           dq: 16'h0000, dqOe: 1'b0};
            done_ff  <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            phase_ff <= nxt_phase;
            cnt_ff   <= nxt_cnt;
            pins_ff  <= nxt_pins;
            done_ff  <= nxt_done;
            rdata_ff <= nxt_rdata;
        end
    end

    assign pins  = pins_ff;
    assign done  = done_ff;
    assign rdata = rdata_ff;

    // RULE_02 write strobe falls inside chip enable with the address settled
    property p_strobeAfterCe;
        @(posedge clk) disable iff (reset)
            $fell(pins_ff.weN) |-> !pins_ff.ceN && $stable(pins_ff.addr);
    endproperty
    a_strobeAfterCe: assert property (p_strobeAfterCe) else $error("we fell without ce"); // RULE_02
    // RULE_17 write strobe only while the data bus is driven
    property p_writeDrivesDq;
        @(posedge clk) disable iff (reset) !pins_ff.weN |-> pins_ff.dqOe && pins_ff.oeN;
    endproperty
    a_writeDrivesDq: assert property (p_writeDrivesDq) else $error("write without dq drive"); // RULE_17
endmodule // fcsm_bus_cycle

// ---- rtl/fcsm_host.sv ----
// host controller: APB registers, flash command sequencer and status polling
`include "fcsm_params.svh"
module fcsm_host (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // flash pins
    output logic             flashCeN,
    output logic             flashWeN,
    output logic             flashOeN,
    output logic      [21:0] flashAddr,
    output logic      [15:0] flashDqOut,
    output logic             flashDqOe,
    input  wire logic [15:0] flashDqIn,
    input  wire logic        readyBusyIn
);
    typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLLWAIT} fcsm_state_e;

    // apb-side registers
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic [21:0] addrReg_ff, nxt_addrReg;
    logic [15:0] wdataReg_ff, nxt_wdataReg;
    logic [15:0] rdataReg_ff, nxt_rdataReg;
    logic [2:0]  op_ff, nxt_op;
    logic        errFlag_ff, nxt_errFlag;
    // sequencer
    fcsm_state_e state_ff, nxt_state;
    logic [2:0]  step_ff, nxt_step;
    logic [2:0]  last_ff, nxt_last;
    logic        start_ff, nxt_start;
    fcsm_pkg::fcsm_cycle_s cyc_ff, nxt_cyc;
    logic [15:0] prevPoll_ff, nxt_prevPoll;
    // ready/busy synchroniser
    logic [2:0]  rbSync_ff;
    logic        rbLevel_ff, nxt_rbLevel;

    logic                 cycDone;
    logic [15:0]          cycRdata;
    fcsm_pkg::fcsm_pins_s pins;
    logic                 busy;
    logic                 apbAccess;

    // build step n of the current command sequence
    function automatic fcsm_pkg::fcsm_cycle_s seqCycle(input logic [2:0] op,
                                                     input logic [2:0] n,
                                                     input logic [21:0] a,
                                                     input logic [15:0] d);
        fcsm_pkg::fcsm_cycle_s c;
        c.write = 1'b1;
        c.addr  = `FCSM_UNLOCK1_ADDR;
        c.data  = `FCSM_UNLOCK1_DATA;
        // RULE_26 unlock pattern
        if (n == 3'd1 || n == 3'd4) begin
            c.addr = `FCSM_UNLOCK2_ADDR;
            c.data = `FCSM_UNLOCK2_DATA;
        end
        case (fcsm_pkg::fcsm_op_e'(op))
            fcsm_pkg::OP_READ: begin
                c.write = 1'b0;
                c.addr  = a;
            end
            // RULE_10 reset write also leaves identification mode
            fcsm_pkg::OP_RESET:   c.data = `FCSM_CMD_RESET;
            fcsm_pkg::OP_SUSPEND: c.data = `FCSM_CMD_SUSPEND;
            fcsm_pkg::OP_RESUME:  c.data = `FCSM_CMD_RESUME;
            fcsm_pkg::OP_IDENT:   if (n == 3'd2) c.data = `FCSM_CMD_IDENT;
            fcsm_pkg::OP_PROGRAM: begin
                // RULE_17 four write cycles
                if (n == 3'd2) c.data = `FCSM_CMD_PROG;
                if (n == 3'd3) begin
                    c.addr = a;
                    c.data = d;
                end
            end
            default: begin
                // RULE_21 six write cycles
                if (n == 3'd2) c.data = `FCSM_CMD_ERSETUP;
                if (n == 3'd5) begin
                    c.addr = (fcsm_pkg::fcsm_op_e'(op) == fcsm_pkg::OP_SECTOR_ERASE) ? a
                             : `FCSM_UNLOCK1_ADDR;
                    c.data = (fcsm_pkg::fcsm_op_e'(op) == fcsm_pkg::OP_SECTOR_ERASE)
                             ? `FCSM_CMD_SECTER : `FCSM_CMD_CHIPER;
                end
            end
        endcase
        return c;
    endfunction

    // number of cycles minus one per operation
    function automatic logic [2:0] seqLast(input logic [2:0] op);
        case (fcsm_pkg::fcsm_op_e'(op))
            fcsm_pkg::OP_PROGRAM:      return 3'd3;
            fcsm_pkg::OP_IDENT:        return 3'd2;
            fcsm_pkg::OP_CHIP_ERASE:   return 3'd5;
            fcsm_pkg::OP_SECTOR_ERASE: return 3'd5;
            default:                   return 3'd0;
        endcase
    endfunction

    fcsm_bus_cycle u_cycle (
        .clk   (clk),
        .reset (reset),
        .start (start_ff),
        .cyc   (cyc_ff),
        .done  (cycDone),
        .rdata (cycRdata),
        .pins  (pins),
        .dqIn  (flashDqIn)
    );
    assign busy      = (state_ff != S_IDLE);
    assign apbAccess = psel && penable && !pready_ff;
    // apb register file; a write of go while busy is dropped
    always_comb begin
        nxt_prdata   = prdata_ff;
        nxt_pready   = 1'b0;
        nxt_pslverr  = 1'b0;
        nxt_addrReg  = addrReg_ff;
        nxt_wdataReg = wdataReg_ff;
        nxt_op       = op_ff;
        // RULE_11 an error seen while polling turns the operation into a reset
        if (state_ff == S_POLLWAIT && cycDone && step_ff != 3'd0 && cycRdata[`FCSM_ERR_BIT] &&
            cycRdata[`FCSM_TOGGLE_BIT] != prevPoll_ff[`FCSM_TOGGLE_BIT])
            nxt_op = 3'(fcsm_pkg::OP_RESET);
        if (apbAccess) begin
            nxt_pready = 1'b1;
            case (paddr)
                `FCSM_REG_CTRL:   nxt_prdata = {25'h0000000, op_ff, 4'h0};
                `FCSM_REG_ADDR:   nxt_prdata = {10'h000, addrReg_ff};
                `FCSM_REG_WDATA:  nxt_prdata = {16'h0000, wdataReg_ff};
                `FCSM_REG_STATUS: nxt_prdata = {29'h00000000, rbLevel_ff, errFlag_ff, busy};
                `FCSM_REG_RDATA:  nxt_prdata = {16'h0000, rdataReg_ff};
                default: begin
                    nxt_prdata  = 32'h00000000;
                    nxt_pslverr = 1'b1;
                end
            endcase
            if (pwrite) begin
                case (paddr)
                    `FCSM_REG_CTRL:  if (!busy) nxt_op = pwdata[`FCSM_CTRL_OP_LSB +: `FCSM_CTRL_OP_W];
                    `FCSM_REG_ADDR:  nxt_addrReg  = pwdata[21:0];
                    `FCSM_REG_WDATA: nxt_wdataReg = pwdata[15:0];
                    default:         nxt_addrReg  = addrReg_ff;
                endcase
            end
        end
    end

    // command sequencer; program and erase are followed by toggle polling
    always_comb begin
        nxt_state    = state_ff;
        nxt_step     = step_ff;
        nxt_last     = last_ff;
        nxt_start    = 1'b0;
        nxt_cyc      = cyc_ff;
        nxt_prevPoll = prevPoll_ff;
        nxt_errFlag  = errFlag_ff;
        nxt_rdataReg = rdataReg_ff;
        case (state_ff)
            S_IDLE: begin
                if (apbAccess && pwrite && paddr == `FCSM_REG_CTRL && pwdata[`FCSM_CTRL_GO]) begin
                    nxt_step    = 3'd0;
                    nxt_last    = seqLast(pwdata[`FCSM_CTRL_OP_LSB +: `FCSM_CTRL_OP_W]);
                    nxt_errFlag = 1'b0;
                    nxt_state   = S_ISSUE;
                end
            end
            S_ISSUE: begin
                // RULE_03 sequence cycles are writes, except the single read cycle of a read operation
                nxt_cyc   = seqCycle(op_ff, step_ff, addrReg_ff, wdataReg_ff);
                nxt_start = 1'b1;
                nxt_state = S_WAIT;
            end
            S_WAIT: begin
                if (cycDone) begin
                    nxt_rdataReg = cycRdata;
                    if (step_ff != last_ff) begin
                        nxt_step  = step_ff + 3'd1;
                        nxt_state = S_ISSUE;
                    end else if (op_ff == 3'(fcsm_pkg::OP_PROGRAM) ||
                                 op_ff == 3'(fcsm_pkg::OP_CHIP_ERASE) ||
                                 op_ff == 3'(fcsm_pkg::OP_SECTOR_ERASE)) begin
                        // status polling restarts its two-read compare
                        nxt_step     = 3'd0;
                        nxt_state    = S_POLL;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_POLL: begin
                nxt_cyc   = '{write: 1'b0, addr: addrReg_ff, data: 16'h0000};
                nxt_start = 1'b1;
                nxt_state = S_POLLWAIT;
            end
            S_POLLWAIT: begin
                if (cycDone) begin
                    nxt_prevPoll = cycRdata;
                    nxt_rdataReg = cycRdata;
                    if (step_ff == 3'd0) begin
                        // the first read only primes the compare; a stale word could fake done
                        nxt_step  = 3'd1;
                        nxt_state = S_POLL;
                    end else if (cycRdata[`FCSM_TOGGLE_BIT] == prevPoll_ff[`FCSM_TOGGLE_BIT]) begin
                        // toggle stopped: algorithm done
                        nxt_state = S_IDLE;
                    end else if (cycRdata[`FCSM_ERR_BIT]) begin
                        // RULE_11 reset after error; op turns to reset in the register block
                        nxt_errFlag = 1'b1;
                        nxt_step    = 3'd0;
                        nxt_last    = 3'd0;
                        nxt_state   = S_ISSUE;
                    end else begin
                        nxt_state = S_POLL;
                    end
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    // registers only; ready/busy passes three flops, level taken when the last two agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_ff   <= 32'h00000000;
            pready_ff   <= 1'b0;
            pslverr_ff  <= 1'b0;
            addrReg_ff  <= 22'h000000;
            wdataReg_ff <= 16'h0000;
            rdataReg_ff <= 16'h0000;
            op_ff       <= 3'h0;
            errFlag_ff  <= 1'b0;
            state_ff    <= S_IDLE;
            step_ff     <= 3'h0;
            last_ff     <= 3'h0;
            start_ff    <= 1'b0;
            cyc_ff      <= '0;
            prevPoll_ff <= 16'h0000;
            rbSync_ff   <= 3'h7;
            rbLevel_ff  <= 1'b1;
        end else begin
            prdata_ff   <= nxt_prdata;
            pready_ff   <= nxt_pready;
            pslverr_ff  <= nxt_pslverr;
            addrReg_ff  <= nxt_addrReg;
            wdataReg_ff <= nxt_wdataReg;
            rdataReg_ff <= nxt_rdataReg;
            op_ff       <= nxt_op;
            errFlag_ff  <= nxt_errFlag;
            state_ff    <= nxt_state;
            step_ff     <= nxt_step;
            last_ff     <= nxt_last;
            start_ff    <= nxt_start;
            cyc_ff      <= nxt_cyc;
            prevPoll_ff <= nxt_prevPoll;
            rbSync_ff   <= {rbSync_ff[1:0], readyBusyIn};
            rbLevel_ff  <= nxt_rbLevel;
        end
    end
    // accept a ready/busy change only once two stages agree
    assign nxt_rbLevel = (rbSync_ff[2] == rbSync_ff[1]) ? rbSync_ff[2] : rbLevel_ff;
    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign flashCeN   = pins.ceN;
    assign flashWeN   = pins.weN;
    assign flashOeN   = pins.oeN;
    assign flashAddr  = pins.addr;
    assign flashDqOut = pins.dq;
    assign flashDqOe  = pins.dqOe;

    // RULE_17 fourth program cycle carries target
    property p_progData;
        @(posedge clk) disable iff (reset)
            (state_ff == S_ISSUE && op_ff == 3'(fcsm_pkg::OP_PROGRAM) && step_ff == 3'd3)
            |=> cyc_ff.addr == addrReg_ff && cyc_ff.data == wdataReg_ff;
    endproperty
    a_progData: assert property (p_progData) else $error("bad program data cycle"); // RULE_17
    // RULE_24 suspend is one write of its code
    property p_suspendCode;
        @(posedge clk) disable iff (reset)
            (state_ff == S_ISSUE && op_ff == 3'(fcsm_pkg::OP_SUSPEND))
            |=> cyc_ff.write && cyc_ff.data == `FCSM_CMD_SUSPEND && last_ff == 3'd0;
    endproperty
    a_suspendCode: assert property (p_suspendCode) else $error("bad suspend write"); // RULE_24

    // RULE_26 first cycle unlock data
    property p_unlockFirst;
        @(posedge clk) disable iff (reset)
            (state_ff == S_ISSUE && step_ff == 3'd0 && last_ff != 3'd0)
            |=> cyc_ff.addr == `FCSM_UNLOCK1_ADDR && cyc_ff.data == `FCSM_UNLOCK1_DATA;
    endproperty
    a_unlockFirst: assert property (p_unlockFirst) else $error("bad first unlock"); // RULE_26

    // RULE_11 error leads to reset write
    sequence s_errSeen;
        state_ff == S_POLLWAIT && cycDone && step_ff != 3'd0 && cycRdata[`FCSM_ERR_BIT] &&
            cycRdata[`FCSM_TOGGLE_BIT] != prevPoll_ff[`FCSM_TOGGLE_BIT];
    endsequence
    property p_errReset;
        @(posedge clk) disable iff (reset) s_errSeen |=> ##1 cyc_ff.data == `FCSM_CMD_RESET;
    endproperty
    a_errReset: assert property (p_errReset) else $error("no reset after error"); // RULE_11
endmodule // fcsm_host

// ---- rtl/fcsm_params.svh ----
// timing constants, command codes and register offsets for the flash host controller
// Behaviour
// RULE_01: sector chosen by address bits 21..16
// RULE_02: address on late fall, data on early rise
// RULE_03: host issues all command cycles as writes
// RULE_04: unlock and command addresses are don't care
// RULE_05: device reads array after power-up and completion
// RULE_06: suspended sector reads return status
// RULE_07: reset command returns to array read
// RULE_08: reset aborts erase set-up, not running erase
// RULE_09: reset aborts program set-up, not running program
// RULE_10: host writes reset to leave identification mode
// RULE_11: on error flag host writes reset
// RULE_12: identification mode answers repeated reads
// RULE_13: id word 00h maker, 01h part
// RULE_14: id word 02h gives sector protection
// RULE_15: address bit 21 picks sector half
// RULE_16: secured indicator 98h/18h or 88h/08h
// RULE_17: word program is four write cycles
// RULE_18: program completion returns to array read
// RULE_19: commands ignored while program runs
// RULE_20: programming never turns 0 into 1
// RULE_21: erase is six write cycles
// RULE_22: suspend only in sector erase; the host launches suspend only while idle, as go is dropped while busy
// RULE_23: wrong write drops device to array read
// RULE_24: suspend B0h, resume 30h
// RULE_25: suspend takes effect within 20 us
// RULE_26: unlock AAh@555h, 55h@2AAh, reset F0h
// RULE_27: ready/busy low while algorithm runs
`ifndef FCSM_PARAMS_SVH
`define FCSM_PARAMS_SVH

// flash command words
`define FCSM_UNLOCK1_ADDR   22'h000555
`define FCSM_UNLOCK2_ADDR   22'h0002AA
`define FCSM_UNLOCK1_DATA   16'h00AA
`define FCSM_UNLOCK2_DATA   16'h0055
`define FCSM_CMD_RESET      16'h00F0
`define FCSM_CMD_IDENT      16'h0090
`define FCSM_CMD_PROG       16'h00A0
`define FCSM_CMD_ERSETUP    16'h0080
`define FCSM_CMD_CHIPER     16'h0010
`define FCSM_CMD_SECTER     16'h0030
`define FCSM_CMD_SUSPEND    16'h00B0
`define FCSM_CMD_RESUME     16'h0030
`define FCSM_ID_WORD_PROT   22'h000002
`define FCSM_SECTOR_LSB     16
`define FCSM_ERR_BIT        5
`define FCSM_TOGGLE_BIT     6

// register offsets (byte addresses)
`define FCSM_REG_CTRL       12'h000
`define FCSM_REG_ADDR       12'h004
`define FCSM_REG_WDATA      12'h008
`define FCSM_REG_STATUS     12'h00C
`define FCSM_REG_RDATA      12'h010

// control register fields
`define FCSM_CTRL_GO        0
`define FCSM_CTRL_OP_LSB    4
`define FCSM_CTRL_OP_W      3

// bus timing in ns, converted to 250 MHz cycles (setup/strobe/read/hold all rounded up)
`define FCSM_CLK_NS         4
`define FCSM_T_SETUP_NS     20
`define FCSM_T_STROBE_NS    40
`define FCSM_T_HOLD_NS      20
`define FCSM_T_READ_NS      120
`define FCSM_CYC(ns)        (((ns) + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)

`endif

// ---- rtl/fcsm_pkg.sv ----
// types shared by the flash host controller files
package fcsm_pkg;
    // operations software can launch
    typedef enum logic [2:0] {
        OP_READ, OP_RESET, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
        OP_IDENT, OP_SUSPEND, OP_RESUME
    } fcsm_op_e;

    // one bus cycle toward the flash
    typedef struct packed {
        logic        write;
        logic [21:0] addr;
        logic [15:0] data;
    } fcsm_cycle_s;

    // flash pin group driven by the host
    typedef struct packed {
        logic        ceN;
        logic        weN;
        logic        oeN;
        logic [21:0] addr;
        logic [15:0] dq;
        logic        dqOe;
    } fcsm_pins_s;
endpackage
